// ===== verilog/sqr_register_control.sv
// Purpose: State and output registers of a logic sequencer with preset,
//          output enable and diagnostic jam and view.
// Assumes: Board pins (clock pin included) are asynchronous; all logic runs
//          on clk_sys and sees pin edges after a three-flop filter.
// Notes:   The AND/OR arrays are outside; they supply next_state and
//          next_output combinationally from the current registers.
//          Pin drive follows the registers in the same cycle; a pin edge
//          takes effect four clk_sys edges after it is first sampled.
module sqr_register_control
    import sqr_pkg::*;
#(
    parameter int unsigned WIDTH = SQR_WIDTH
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic             seq_clk_pin,
    input  wire logic             preset_or_output_enable,
    input  wire logic             diag_select_a,
    input  wire logic             diag_select_b,
    input  wire logic             diag_select_view,
    input  wire logic             jam_to_state,
    input  wire logic [WIDTH-1:0] next_state,
    input  wire logic [WIDTH-1:0] next_output,
    input  wire logic [WIDTH-1:0] function_pins_in,
    output logic      [WIDTH-1:0] function_pins_out,
    output logic      [WIDTH-1:0] function_pins_oe_n,
    output logic      [WIDTH-1:0] state_reg,
    output logic      [WIDTH-1:0] output_reg,
    output logic                  diag_mode
);

    // Only the eight-bit register width is served by the pin mapping
    if (WIDTH != SQR_WIDTH) begin : g_width_chk
        $error("sqr_register_control: WIDTH 8 only");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // Every board pin, the sequencer clock included, is filtered so that
    // a level counts only once two stages agree. The price is latency:
    // pulses shorter than about two clk_sys cycles may be lost, so the
    // sequencer clock must stay high and low at least that long each.

    // Width of the packed control pin group
    localparam int unsigned CW = 5;
    sqr_ctrl_t        ctrl_raw, ctrl_s;
    logic [CW-1:0]    ctrl_sync;
    logic [WIDTH-1:0] fpin_s;
    logic [CW-1:0]    ctrl_rst;

    // Pack the pin levels so one synchroniser filters them all alike
    assign ctrl_raw = '{preset_or_output_enable: preset_or_output_enable,
                        diag_select_a:           diag_select_a,
                        diag_select_b:           diag_select_b,
                        diag_select_view:        diag_select_view,
                        clk_pin:                 seq_clk_pin};
    // Preset pin idles high after reset so no false preset edge appears
    assign ctrl_rst = 5'h10;
    assign ctrl_s   = sqr_ctrl_t'(ctrl_sync);

    // Control pins share one delay, so joint switches stay aligned
    sqr_sync #(.WIDTH(CW)) u_sync_ctrl (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .async_in  (ctrl_raw),
        .reset_val (ctrl_rst),
        .sync_out  (ctrl_sync)
    );

    // Function pins feed only the diagnostic jam path
    sqr_sync #(.WIDTH(WIDTH)) u_sync_fpin (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .clk_en    (clk_en),
        .async_in  (function_pins_in),
        .reset_val (SQR_RESET_VAL),
        .sync_out  (fpin_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Edge detection on filtered pins
    // Each history flop resets to the idle level of its pin, so releasing
    // reset never looks like a clock or preset edge.

    logic ck_prev_q, ck_prev_d;
    logic pr_prev_q, pr_prev_d;
    logic ck_rise, pr_rise;

    // Edges compare filtered values only, never the first sync stage
    always_comb begin
        ck_prev_d = ctrl_s.clk_pin;
        pr_prev_d = ctrl_s.preset_or_output_enable;
        ck_rise   = ctrl_s.clk_pin & ~ck_prev_q;
        pr_rise   = ctrl_s.preset_or_output_enable & ~pr_prev_q;
    end

    // Previous filtered levels of the clock and preset pins
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ck_prev_q <= 1'b0;
            pr_prev_q <= 1'b1;
        end else if (clk_en) begin
            ck_prev_q <= ck_prev_d;
            pr_prev_q <= pr_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode

    // A select at the high-voltage level reaches us as a plain logic one;
    // any one of the three selects is enough to enter diagnostic mode
    logic diag_any;
    // R6 diagnostic entry
    assign diag_any  = ctrl_s.diag_select_a | ctrl_s.diag_select_b |
                       ctrl_s.diag_select_view;
    assign diag_mode = diag_any;

    // Priority: preset edge, then jam in diagnostic mode, then normal clock
    // A clock edge meeting a preset edge is dropped, never half applied
    function automatic sqr_op_t sqr_pick_op(input logic pr_edge,
                                            input logic ck_edge,
                                            input logic diag);
        if (pr_edge) begin
            return SQR_PRESET;
        end else if (ck_edge && diag) begin
            return SQR_JAM;
        end else if (ck_edge) begin
            return SQR_NEXT;
        end
        return SQR_HOLD;
    endfunction : sqr_pick_op

    ////////////////////////////////////////////////////////////////////////
    // State and output registers

    sqr_op_t          op;
    logic [WIDTH-1:0] state_q, state_d;
    logic [WIDTH-1:0] outr_q, outr_d;

    // Next register contents for the chosen operation
    always_comb begin
        op      = sqr_pick_op(pr_rise, ck_rise, diag_any);
        state_d = state_q;
        outr_d  = outr_q;
        unique case (op)
            // R3 preset forces ones
            SQR_PRESET: begin
                state_d = SQR_RESET_VAL;
                outr_d  = SQR_RESET_VAL;
            end
            // R7 diagnostic jam load
            SQR_JAM: begin
                if (jam_to_state) begin
                    state_d = fpin_s;
                end else begin
                    outr_d = fpin_s;
                end
            end
            // R1 update on clock rise
            SQR_NEXT: begin
                state_d = next_state;
                outr_d  = next_output;
            end
            // R12 hold between edges
            SQR_HOLD: begin
                state_d = state_q;
                outr_d  = outr_q;
            end
        endcase
    end

    // R4 all high after reset
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= SQR_RESET_VAL;
            outr_q  <= SQR_RESET_VAL;
        end else if (clk_en) begin
            state_q <= state_d;
            outr_q  <= outr_d;
        end
    end

    // Register contents for the array logic outside
    assign state_reg  = state_q;
    assign output_reg = outr_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers

    // The drive is built from the next register values, so the pins show
    // the same contents as state_reg or output_reg in every cycle.
    logic [WIDTH-1:0] pout_q, pout_d;
    logic [WIDTH-1:0] poe_n_q, poe_n_d;

    // Pin data and enable; enable off while preset or in diagnostic mode
    always_comb begin
        // R8 view state register / R9 back to output register
        pout_d = ctrl_s.diag_select_view ? state_d : outr_d;
        // R2 enable pin gates drive; R6 pins are inputs in diagnostic mode
        if (ctrl_s.preset_or_output_enable || diag_any) begin
            poe_n_d = {WIDTH{1'b1}};
        end else begin
            poe_n_d = '0;
        end
    end

    // Registered so data outputs never glitch; reset leaves the pins off
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pout_q  <= SQR_RESET_VAL;
            poe_n_q <= SQR_RESET_VAL;
        end else if (clk_en) begin
            pout_q  <= pout_d;
            poe_n_q <= poe_n_d;
        end
    end

    // Pin drive and its active-low enable
    assign function_pins_out  = pout_q;
    assign function_pins_oe_n = poe_n_q;

endmodule : sqr_register_control

// ===== verilog/sqr_pkg.sv
// Purpose: Shared constants and types for the sequencer register control.
// Assumes: One 100 MHz clock, synchronous active-low reset.
// Notes:   Pins are sampled through three flops before use.
//
// Overview of operation
// R1 - Registers update on rising clock; outputs valid while preset/enable low.
// R2 - Preset/enable high puts outputs off; low drives them.
// R3 - Rising preset edge forces registered outputs to all ones.
// R4 - Reset sets every state and output register bit high.
// R5 - Programmed logic must leave the all-high state if unwanted.
// R6 - Any diagnostic select high enters diagnostic mode; function pins become inputs.
// R7 - In diagnostic mode a clock edge jams function pins into a register.
// R8 - Diagnostic view select shows state register on the outputs.
// R9 - View select back to normal shows output register again.
// R10 - Diagnostic select held until after the loading clock edge.
// R11 - Party waits after preset release before first clock edge.
// R12 - Registers hold their values when no load or preset occurs.
package sqr_pkg;

    localparam int unsigned SQR_WIDTH     = 8;
    localparam logic [7:0]  SQR_RESET_VAL = 8'hff;
    localparam int unsigned SQR_SYNC_LEN  = 3;

    // Board pins as seen by the block after synchronising
    typedef struct packed {
        logic       preset_or_output_enable;
        logic       diag_select_a;
        logic       diag_select_b;
        logic       diag_select_view;
        logic       clk_pin;
    } sqr_ctrl_t;

    // Register update kinds
    typedef enum logic [3:0] {
        SQR_HOLD   = 4'h1,
        SQR_PRESET = 4'h2,
        SQR_NEXT   = 4'h4,
        SQR_JAM    = 4'h8
    } sqr_op_t;

endpackage : sqr_pkg

// ===== verilog/sqr_sync.sv
// Purpose: Three-flop synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   The first flop feeds only the second.
module sqr_sync
    import sqr_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
    logic [WIDTH-1:0] s1_d, s2_d, s3_d, out_d;

    // A zero-width filter has nothing to carry
    if (WIDTH < 1) begin : g_width_chk
        $error("sqr_sync: WIDTH must be at least 1");
    end

    // Accept a change only when the second and third stage agree
    always_comb begin
        s1_d  = async_in;
        s2_d  = s1_q;
        s3_d  = s2_q;
        out_d = out_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    // Reset value is held in registers; the port is sampled only on edges
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s1_q  <= reset_val;
            s2_q  <= reset_val;
            s3_q  <= reset_val;
            out_q <= reset_val;
        end else if (clk_en) begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            out_q <= out_d;
        end
    end

    assign sync_out = out_q;

endmodule : sqr_sync

// ===== tb/sqr_board_model.sv
// Purpose: Board array logic that feeds the next register values.
// Assumes: Combinational, like the fuse arrays it stands for.
// Notes:   Counting up leaves the all-high start on the first clock.
module sqr_board_model
    import sqr_pkg::*;
(
    input  wire logic [SQR_WIDTH-1:0] state_reg,
    output logic      [SQR_WIDTH-1:0] next_state,
    output logic      [SQR_WIDTH-1:0] next_output
);
    timeunit 1ns;
    timeprecision 1ns;
    assign next_state  = state_reg + 8'h01;
    assign next_output = ~state_reg;
endmodule : sqr_board_model

// ===== tb/sqr_register_control_assertions.sv
// Purpose: Port checks for the sequencer register control.
// Assumes: Pin levels last at least 4 clk_sys cycles.
// Notes:   Delays follow the three-flop pin filter.
module sqr_register_control_assertions
    import sqr_pkg::*;
#(
    parameter int unsigned WIDTH = SQR_WIDTH
) (
    input wire logic             clk_sys,
    input wire logic             resetn,
    input wire logic             clk_en,
    input wire logic             seq_clk_pin,
    input wire logic             preset_or_output_enable,
    input wire logic             diag_select_a,
    input wire logic             diag_select_b,
    input wire logic             diag_select_view,
    input wire logic             jam_to_state,
    input wire logic [WIDTH-1:0] next_state,
    input wire logic [WIDTH-1:0] next_output,
    input wire logic [WIDTH-1:0] function_pins_in,
    input wire logic [WIDTH-1:0] function_pins_out,
    input wire logic [WIDTH-1:0] function_pins_oe_n,
    input wire logic [WIDTH-1:0] state_reg,
    input wire logic [WIDTH-1:0] output_reg,
    input wire logic             diag_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    logic any_diag;
    // Any select at the diagnostic level
    assign any_diag = diag_select_a | diag_select_b | diag_select_view;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // A pin clock rise that the filter accepts while enabled
    sequence ck_rise_s;
        $rose(seq_clk_pin) && clk_en ##1 (seq_clk_pin && clk_en)[*3];
    endsequence
    reset_high_a: assert property ($rose(resetn) |->
        state_reg == SQR_RESET_VAL && output_reg == SQR_RESET_VAL)
        else $error("regs not high after reset");
    clock_load_a: assert property (ck_rise_s ##0 !diag_mode |-> ##2
        state_reg == $past(next_state) && output_reg == $past(next_output))
        else $error("clock load wrong");
    jam_load_a: assert property (ck_rise_s ##0 diag_mode |-> ##2
        (jam_to_state ? state_reg : output_reg) == function_pins_in)
        else $error("jam load wrong");
    preset_ones_a: assert property ($rose(preset_or_output_enable)
        ##1 preset_or_output_enable[*7] |-> &state_reg && &output_reg)
        else $error("preset not all ones");
    outputs_off_a: assert property (preset_or_output_enable[*6] |->
        &function_pins_oe_n) else $error("outputs not off");
    outputs_on_a: assert property ((
        !preset_or_output_enable && !any_diag)[*8] |->
        function_pins_oe_n == 8'h00) else $error("outputs not driven");
    diag_enter_a: assert property (any_diag[*6] |-> diag_mode)
        else $error("diag mode missing");
    diag_inputs_a: assert property (diag_mode[*3] |->
        &function_pins_oe_n) else $error("pins not inputs");
    view_state_a: assert property (diag_select_view[*7] |->
        function_pins_out == state_reg) else $error("no state view");
    view_output_a: assert property (!diag_select_view[*7] |->
        function_pins_out == output_reg) else $error("no out view");
    freeze_hold_a: assert property (!clk_en |=>
        $stable(state_reg) && $stable(output_reg)) else $error("not held");
endmodule : sqr_register_control_assertions

// ===== tb/test_sqr_register_control.sv
// Purpose: Directed bench for the sequencer register control.
// Assumes: Pins change just after a clk_sys rise.
// Notes:   Pin levels last at least 5 cycles, above the filter minimum.
module test_sqr_register_control
    import sqr_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys, resetn, clk_en, seq_clk_pin, jam_to_state;
    logic       preset_or_output_enable, diag_mode;
    logic       diag_select_a, diag_select_b, diag_select_view;
    logic [7:0] next_state, next_output, function_pins_in, board_q;
    logic [7:0] function_pins_out, function_pins_oe_n, state_reg, output_reg;
    int         n_mismatch, comparisons;
    // Board drives only in diagnostic mode; an undriven pin flips
    assign function_pins_in = !function_pins_oe_n[0] ? function_pins_out :
        (diag_select_a | diag_select_b | diag_select_view) ? board_q :
        ~function_pins_out;
    sqr_register_control dut_u (.*);
    sqr_board_model board_u (.*);
    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle
    // One pin clock, each level long enough for the filter
    task automatic pulse();
        @(posedge clk_sys) seq_clk_pin <= 1'b1;
        idle(5);
        seq_clk_pin <= 1'b0;
        idle(5);
    endtask : pulse
    // Normal clocking from the all-high start, then holding
    task automatic t_run();
        pulse();
        cmp("state", 8'h00, state_reg);
        cmp("output", 8'h00, output_reg);
        pulse();
        cmp("state", 8'h01, state_reg);
        cmp("pins", 8'hff, function_pins_out);
        cmp("oe_n", 8'h00, function_pins_oe_n);
        idle(20);
        cmp("held", 8'h01, state_reg);
    endtask : t_run
    // Preset pulse, then a quiet gap before the next clock
    task automatic t_preset();
        preset_or_output_enable <= 1'b1;
        idle(8);
        cmp("state", 8'hff, state_reg);
        cmp("output", 8'hff, output_reg);
        cmp("oe_n", 8'hff, function_pins_oe_n);
        preset_or_output_enable <= 1'b0;
        idle(8);
    endtask : t_preset
    // Jam into both registers; select held past the loading edge
    task automatic t_jam();
        diag_select_a <= 1'b1;
        jam_to_state <= 1'b1;
        board_q <= 8'h5a;
        idle(8);
        cmp("diag", 8'h01, {7'h00, diag_mode});
        cmp("oe_n", 8'hff, function_pins_oe_n);
        pulse();
        cmp("state", 8'h5a, state_reg);
        jam_to_state <= 1'b0;
        board_q <= 8'ha5;
        pulse();
        cmp("output", 8'ha5, output_reg);
        cmp("state", 8'h5a, state_reg);
    endtask : t_jam
    // View the state register, then return to the output register
    task automatic t_view();
        diag_select_view <= 1'b1;
        idle(8);
        cmp("pins", 8'h5a, function_pins_out);
        diag_select_view <= 1'b0;
        diag_select_a <= 1'b0;
        diag_select_b <= 1'b1;
        idle(8);
        cmp("diag", 8'h01, {7'h00, diag_mode});
        diag_select_b <= 1'b0;
        idle(8);
        cmp("pins", 8'ha5, function_pins_out);
        cmp("oe_n", 8'h00, function_pins_oe_n);
    endtask : t_view
    // A pin clock while frozen must not load
    task automatic t_freeze();
        clk_en <= 1'b0;
        pulse();
        clk_en <= 1'b1;
        idle(8);
        cmp("state", 8'h5a, state_reg);
    endtask : t_freeze
    task automatic summarize();
        $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize
    // Main sequence: reset held 6 cycles with every input defined
    initial begin
        {resetn, seq_clk_pin, preset_or_output_enable, jam_to_state} = 4'h0;
        {diag_select_a, diag_select_b, diag_select_view} = 3'h0;
        clk_en = 1'b1;
        board_q = 8'h00;
        n_mismatch = 0;
        comparisons = 0;
        idle(6);
        cmp("state", SQR_RESET_VAL, state_reg);
        cmp("output", SQR_RESET_VAL, output_reg);
        resetn <= 1'b1;
        idle(8);
        t_run();
        t_preset();
        t_jam();
        t_view();
        t_freeze();
        summarize();
    end
endmodule : test_sqr_register_control
bind sqr_register_control sqr_register_control_assertions #(.WIDTH(WIDTH))
    chk_u (.*);
